// ---- hdl/cmc_cfg.svh ----
// offsets, field positions, reset values and write masks of the can control block
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH

// register byte offsets inside the peripheral window
`define CMC_PAGE          8'hc0
`define CMC_OFF_CTRL      16'hc000
`define CMC_OFF_CFG       16'hc010
`define CMC_OFF_INT       16'hc020
`define CMC_OFF_VEC       16'hc030
`define CMC_OFF_TREC      16'hc040
`define CMC_OFF_FSTAT     16'hc050
`define CMC_OFF_RXOVF     16'hc060
`define CMC_OFF_TMR       16'hc070
`define CMC_OFF_MASK0     16'hc080
`define CMC_OFF_MASK1     16'hc0a0
`define CMC_OFF_MASK2     16'hc0b0
`define CMC_OFF_MASK3     16'hc0b0
`define CMC_OFF_FILT0     16'hc0c0
`define CMC_OFF_FILT1     16'hc0d0
`define CMC_OFF_FILT2     16'hc0e0
`define CMC_OFF_FILT3     16'hc0f0

// control and interrupt register field positions
`define CMC_CTRL_ABORT    27
`define CMC_CTRL_REQ_LSB  24
`define CMC_CTRL_CUR_LSB  21
`define CMC_CTRL_CAP      20
`define CMC_CTRL_ON       15
`define CMC_CTRL_SIDLE    13
`define CMC_CTRL_BUSY     11
`define CMC_CTRL_DNCNT_LSB 0
`define CMC_INT_MOD       3
`define CMC_INT_TMR       2

// reset values
`define CMC_RST_CTRL      32'h0480_0000
`define CMC_RST_ZERO      32'h0000_0000
`define CMC_RST_VEC       32'h0000_0040
`define CMC_RST_MODE      3'h4

// implemented bits, for control only the writable ones; elsewhere the rest read zero and ignore writes
`define CMC_WM_CTRL       32'h0710_a01f
`define CMC_WM_CFG        32'h0047_ffff
`define CMC_WM_INT        32'hf80f_f80f
`define CMC_WM_INT_FLAGS  16'hf80f
`define CMC_WM_VEC        32'h0000_1f7f
`define CMC_WM_TREC       32'h003f_ffff
`define CMC_WM_MASK       32'hffeb_ffff
`define CMC_WM_ALL        32'hffff_ffff

// axi4-lite responses
`define CMC_RESP_OKAY     2'h0
`define CMC_RESP_SLVERR   2'h2

`endif

// ---- hdl/cmc_pkg.sv ----
// types shared by the can control block
package cmc_pkg;

  typedef enum logic [2:0] {
    CMC_MODE_NORMAL      = 3'h0,
    CMC_MODE_DISABLE     = 3'h1,
    CMC_MODE_LOOPBACK    = 3'h2,
    CMC_MODE_LISTEN_ONLY = 3'h3,
    CMC_MODE_CONFIG      = 3'h4,
    CMC_MODE_RSVD5       = 3'h5,
    CMC_MODE_RSVD6       = 3'h6,
    CMC_MODE_LISTEN_ALL  = 3'h7
  } cmc_op_mode_t;

  typedef enum logic [1:0] {
    CMC_ALIAS_WRITE = 2'h0,
    CMC_ALIAS_CLR   = 2'h1,
    CMC_ALIAS_SET   = 2'h2,
    CMC_ALIAS_INV   = 2'h3
  } cmc_alias_t;

  typedef enum logic {
    CMC_MS_IDLE   = 1'b0,
    CMC_MS_SWITCH = 1'b1
  } cmc_mode_state_t;

  // control handed to the protocol engine
  typedef struct packed {
    logic         module_en;
    logic         abort_all_tx;
    cmc_op_mode_t op_mode;
    logic         switch_pending;
    logic         stop_in_idle;
    logic [4:0]   dncnt;
    logic [31:0]  bit_timing;
  } cmc_ctl_t;

  // status reported by the protocol engine
  typedef struct packed {
    logic         module_active_flag;
    logic         tx_aborted_all;
    logic         mode_safe;
    logic         rx_valid;
    logic [15:0]  int_events;
    logic [31:0]  vector;
    logic [31:0]  err_counters;
    logic [31:0]  fifo_pending;
    logic [31:0]  rx_ovf_set;
  } cmc_stat_t;

endpackage

// ---- hdl/cmc_mode_ctrl.sv ----
// operating-mode request and status handshake
`timescale 1ns/1ps
`include "cmc_cfg.svh"

module cmc_mode_ctrl (
  input  logic                  aclk,
  input  logic                  aresetn,
  input  cmc_pkg::cmc_op_mode_t req_mode,
  input  logic                  mode_safe,
  output cmc_pkg::cmc_op_mode_t cur_mode,
  output logic                  switch_pending,
  output logic                  mode_changed
);

  cmc_pkg::cmc_mode_state_t state_reg, state_next;
  cmc_pkg::cmc_op_mode_t    cur_reg, cur_next;
  logic                     chg_reg, chg_next;
  logic                     req_ok;

  assign req_ok = (req_mode != cmc_pkg::CMC_MODE_RSVD5) && (req_mode != cmc_pkg::CMC_MODE_RSVD6);

  always_comb begin
    state_next = state_reg;
    cur_next   = cur_reg;
    chg_next   = 1'b0;
    case (state_reg)
      cmc_pkg::CMC_MS_IDLE: begin
        if (req_ok && (req_mode != cur_reg)) begin
          state_next = cmc_pkg::CMC_MS_SWITCH;
        end
      end
      cmc_pkg::CMC_MS_SWITCH: begin
        if (!req_ok || (req_mode == cur_reg)) begin
          state_next = cmc_pkg::CMC_MS_IDLE;
        end else if (mode_safe) begin
          cur_next   = req_mode;
          chg_next   = 1'b1;
          state_next = cmc_pkg::CMC_MS_IDLE;
        end
      end
      default: begin
        state_next = cmc_pkg::CMC_MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= cmc_pkg::CMC_MS_IDLE;
      cur_reg   <= cmc_pkg::cmc_op_mode_t'(`CMC_RST_MODE);
      chg_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg   <= cur_next;
      chg_reg   <= chg_next;
    end
  end

  assign cur_mode       = cur_reg;
  assign switch_pending = (state_reg == cmc_pkg::CMC_MS_SWITCH);
  assign mode_changed   = chg_reg;

endmodule

// ---- hdl/cmc_ts_timer.sv ----
// receive timestamp timer with prescaler and capture
`timescale 1ns/1ps
`include "cmc_cfg.svh"

module cmc_ts_timer (
  input  logic        aclk,
  input  logic        aresetn,
  input  logic        cap_en,
  input  logic        wr_en,
  input  logic [31:0] wr_data,
  input  logic        rx_valid,
  output logic [31:0] timer,
  output logic [15:0] stamp,
  output logic        stamp_valid,
  output logic        rollover
);

  logic [31:0] tmr_reg, tmr_next;
  logic [15:0] pre_reg, pre_next;
  logic [15:0] stamp_reg, stamp_next;
  logic        sv_reg, sv_next;
  logic        roll_reg, roll_next;

  always_comb begin
    tmr_next   = tmr_reg;
    pre_next   = pre_reg;
    stamp_next = stamp_reg;
    sv_next    = 1'b0;
    roll_next  = 1'b0;
    if (wr_en) begin
      tmr_next = wr_data;
      pre_next = 16'h0000;
    end else if (cap_en) begin
      // upper half counts once per prescaler period
      if (pre_reg >= tmr_reg[15:0]) begin
        pre_next       = 16'h0000;
        tmr_next[31:16] = tmr_reg[31:16] + 16'h0001;
        roll_next      = (tmr_reg[31:16] == 16'hffff);
      end else begin
        pre_next = pre_reg + 16'h0001;
      end
    end
    if (cap_en && rx_valid) begin
      stamp_next = tmr_reg[31:16];
      sv_next    = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_reg   <= `CMC_RST_ZERO;
      pre_reg   <= 16'h0000;
      stamp_reg <= 16'h0000;
      sv_reg    <= 1'b0;
      roll_reg  <= 1'b0;
    end else begin
      tmr_reg   <= tmr_next;
      pre_reg   <= pre_next;
      stamp_reg <= stamp_next;
      sv_reg    <= sv_next;
      roll_reg  <= roll_next;
    end
  end

  assign timer       = tmr_reg;
  assign stamp       = stamp_reg;
  assign stamp_valid = sv_reg;
  assign rollover    = roll_reg;

endmodule

// ---- hdl/cmc_can_module_control.sv ----
// axi4-lite register block and control logic of the can controller
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cmc_cfg.svh"

module cmc_can_module_control (
  input  logic                aclk,
  input  logic                aresetn,
  input  logic [31:0]         s_axi_awaddr,
  input  logic                s_axi_awvalid,
  output logic                s_axi_awready,
  input  logic [31:0]         s_axi_wdata,
  input  logic [3:0]          s_axi_wstrb,
  input  logic                s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  logic                s_axi_bready,
  input  logic [31:0]         s_axi_araddr,
  input  logic                s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  logic                s_axi_rready,
  input  cmc_pkg::cmc_stat_t  eng_stat,
  output cmc_pkg::cmc_ctl_t   eng_ctl,
  output logic [3:0][31:0]    accept_mask,
  output logic [3:0][31:0]    filter_ctrl,
  output logic [15:0]         rx_stamp,
  output logic                rx_stamp_valid,
  output logic                irq
);

  localparam logic [3:0][15:0] MASK_OFF = {`CMC_OFF_MASK3, `CMC_OFF_MASK2,
                                           `CMC_OFF_MASK1, `CMC_OFF_MASK0};
  localparam logic [3:0][15:0] FILT_OFF = {`CMC_OFF_FILT3, `CMC_OFF_FILT2,
                                           `CMC_OFF_FILT1, `CMC_OFF_FILT0};

  // bus handshake state
  logic              aw_held_reg, aw_held_next;
  logic [15:0]       aw_addr_reg, aw_addr_next;
  logic              w_held_reg, w_held_next;
  logic [31:0]       w_data_reg, w_data_next;
  logic [3:0]        w_strb_reg, w_strb_next;
  logic              awready_reg, awready_next;
  logic              wready_reg, wready_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;

  // register contents
  logic [31:0]       ctrl_reg, ctrl_next;
  logic              abort_reg, abort_next;
  logic [31:0]       cfg_reg, cfg_next;
  logic [31:0]       int_reg, int_next;
  logic [31:0]       vec_reg, vec_next;
  logic [31:0]       trec_reg, trec_next;
  logic [31:0]       fstat_reg, fstat_next;
  logic [31:0]       rxovf_reg, rxovf_next;
  logic [3:0][31:0]  mask_reg, mask_next;
  logic [3:0][31:0]  filt_reg, filt_next;
  logic              busy_reg, busy_next;
  logic              irq_reg, irq_next;

  // decode and helper signals
  logic                  do_write;
  logic [15:0]           wr_base;
  cmc_pkg::cmc_alias_t   wr_op;
  logic [31:0]           wr_bits;
  logic                  wr_hit;
  logic                  ar_take;
  logic [15:0]           rd_base;
  logic [31:0]           rd_val;
  logic                  rd_hit;
  logic [31:0]           ctrl_view;
  logic [31:0]           ctrl_res;
  logic [31:0]           tmr_val;
  logic [31:0]           tmr_wr_data;
  logic [31:0]           int_en_w, int_fl_w;
  logic                  tmr_wr_en;
  logic [15:0]           int_events;
  logic                  mode_changed;
  logic                  ts_roll;
  logic                  switch_pending;
  cmc_pkg::cmc_op_mode_t cur_mode;

  function automatic logic [31:0] cmc_apply(input logic [31:0]         old,
                                            input logic [31:0]         bits,
                                            input cmc_pkg::cmc_alias_t op,
                                            input logic [31:0]         impl);
    logic [31:0] r;
    r = old;
    case (op)
      cmc_pkg::CMC_ALIAS_WRITE: r = bits;
      cmc_pkg::CMC_ALIAS_CLR:   r = old & ~bits;
      cmc_pkg::CMC_ALIAS_SET:   r = old | bits;
      cmc_pkg::CMC_ALIAS_INV:   r = old ^ bits;
      default:                  r = old;
    endcase
    return r & impl;
  endfunction

  // sticky flags: a plain write of ones clears them, like the clear alias
  function automatic logic [31:0] cmc_apply_w1c(input logic [31:0]         old,
                                                input logic [31:0]         bits,
                                                input cmc_pkg::cmc_alias_t op);
    logic [31:0] r;
    r = old;
    case (op)
      cmc_pkg::CMC_ALIAS_WRITE: r = old & ~bits;
      cmc_pkg::CMC_ALIAS_CLR:   r = old & ~bits;
      cmc_pkg::CMC_ALIAS_SET:   r = old | bits;
      cmc_pkg::CMC_ALIAS_INV:   r = old ^ bits;
      default:                  r = old;
    endcase
    return r;
  endfunction

  // alias decode from address bits 3:2
  assign wr_base  = {aw_addr_reg[15:4], 4'h0};
  assign wr_op    = cmc_pkg::cmc_alias_t'(aw_addr_reg[3:2]);
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign ar_take  = s_axi_arvalid && arready_reg;
  assign rd_base  = {s_axi_araddr[15:4], 4'h0};
  assign int_en_w = cmc_apply(int_reg, wr_bits, wr_op, `CMC_WM_INT);
  assign int_fl_w = cmc_apply_w1c(int_reg, wr_bits & `CMC_WM_INT, wr_op);

  // unstrobed bytes are masked here as zeros: the aliases and flag clears keep them, a plain write stores zero
  always_comb begin
    wr_bits = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      wr_bits[b*8 +: 8] = w_strb_reg[b] ? w_data_reg[b*8 +: 8] : 8'h00;
    end
  end

  // only implemented fields are assembled, others read zero
  assign ctrl_view = {4'h0, abort_reg, ctrl_reg[26:24], cur_mode, ctrl_reg[`CMC_CTRL_CAP],
                      4'h0, ctrl_reg[15:12], busy_reg, ctrl_reg[10:0]};
  assign int_events = (eng_stat.int_events & `CMC_WM_INT_FLAGS)
                      & ~(16'h0001 << `CMC_INT_MOD) & ~(16'h0001 << `CMC_INT_TMR)
                      | ({15'h0000, mode_changed} << `CMC_INT_MOD)
                      | ({15'h0000, ts_roll} << `CMC_INT_TMR);

  // read multiplexer
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_base)
      `CMC_OFF_CTRL:  rd_val = ctrl_view;
      `CMC_OFF_CFG:   rd_val = cfg_reg;
      `CMC_OFF_INT:   rd_val = int_reg;
      `CMC_OFF_VEC:   rd_val = vec_reg;
      `CMC_OFF_TREC:  rd_val = trec_reg;
      `CMC_OFF_FSTAT: rd_val = fstat_reg;
      `CMC_OFF_RXOVF: rd_val = rxovf_reg;
      `CMC_OFF_TMR:   rd_val = tmr_val;
      default:        rd_hit = 1'b0;
    endcase
    for (int k = 3; k >= 0; k--) begin
      if (rd_base == MASK_OFF[k]) begin
        rd_val = mask_reg[k];
        rd_hit = 1'b1;
      end
      if (rd_base == FILT_OFF[k]) begin
        rd_val = filt_reg[k];
        rd_hit = 1'b1;
      end
    end
    if (s_axi_araddr[15:8] != `CMC_PAGE) begin
      rd_hit = 1'b0;
      rd_val = 32'h0000_0000;
    end
  end

  // bus handshake next state
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg && !s_axi_bready;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr[15:0];
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_hit ? `CMC_RESP_OKAY : `CMC_RESP_SLVERR;
    end
    awready_next = !aw_held_next;
    wready_next  = !w_held_next;
    rvalid_next  = ar_take || (rvalid_reg && !s_axi_rready);
    arready_next = !rvalid_next;
    rdata_next   = ar_take ? rd_val : rdata_reg;
    rresp_next   = ar_take ? (rd_hit ? `CMC_RESP_OKAY : `CMC_RESP_SLVERR) : rresp_reg;
  end

  // register file next state
  always_comb begin
    ctrl_next   = ctrl_reg;
    cfg_next    = cfg_reg;
    int_next    = int_reg;
    mask_next   = mask_reg;
    filt_next   = filt_reg;
    rxovf_next  = rxovf_reg;
    tmr_wr_en   = 1'b0;
    tmr_wr_data = tmr_val;
    ctrl_res    = ctrl_view;
    wr_hit      = aw_addr_reg[15:8] == `CMC_PAGE;
    if (do_write && wr_hit) begin
      case (wr_base)
        `CMC_OFF_CTRL: begin
          ctrl_res  = cmc_apply(ctrl_view, wr_bits, wr_op, `CMC_WM_CTRL | 32'h0800_0000);
          // enable and other writable control fields
          ctrl_next = ctrl_res & `CMC_WM_CTRL;
        end
        `CMC_OFF_CFG:   cfg_next = cmc_apply(cfg_reg, wr_bits, wr_op, `CMC_WM_CFG);
        `CMC_OFF_INT:   int_next = {int_en_w[31:16], int_fl_w[15:0]};
        `CMC_OFF_RXOVF: rxovf_next = cmc_apply_w1c(rxovf_reg, wr_bits, wr_op);
        `CMC_OFF_TMR: begin
          tmr_wr_en   = 1'b1;
          tmr_wr_data = cmc_apply(tmr_val, wr_bits, wr_op, `CMC_WM_ALL);
        end
        `CMC_OFF_VEC, `CMC_OFF_TREC, `CMC_OFF_FSTAT: begin
          wr_hit = 1'b1;
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      for (int k = 0; k < 4; k++) begin
        if (wr_base == MASK_OFF[k]) begin
          mask_next[k] = cmc_apply(mask_reg[k], wr_bits, wr_op, `CMC_WM_MASK);
          wr_hit       = 1'b1;
        end
        if (wr_base == FILT_OFF[k]) begin
          filt_next[k] = cmc_apply(filt_reg[k], wr_bits, wr_op, `CMC_WM_ALL);
          wr_hit       = 1'b1;
        end
      end
    end else if (do_write) begin
      wr_hit = 1'b0;
    end
    // software only sets; hardware clears after all aborted, set wins
    abort_next = (abort_reg && !eng_stat.tx_aborted_all) ||
                 (do_write && wr_hit && (wr_base == `CMC_OFF_CTRL) && ctrl_res[`CMC_CTRL_ABORT]);
    // hardware events win over a clear in the same cycle
    int_next[15:0] = int_next[15:0] | int_events;
    rxovf_next     = rxovf_next | eng_stat.rx_ovf_set;
    vec_next       = eng_stat.vector & `CMC_WM_VEC;
    trec_next      = eng_stat.err_counters & `CMC_WM_TREC;
    fstat_next     = eng_stat.fifo_pending;
    busy_next      = eng_stat.module_active_flag;
    irq_next       = |(int_next[15:0] & int_next[31:16]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 16'h0000;
      w_held_reg  <= 1'b0;
      w_data_reg  <= `CMC_RST_ZERO;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `CMC_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= `CMC_RST_ZERO;
      rresp_reg   <= `CMC_RESP_OKAY;
      ctrl_reg    <= `CMC_RST_CTRL & `CMC_WM_CTRL;
      abort_reg   <= 1'b0;
      cfg_reg     <= `CMC_RST_ZERO;
      int_reg     <= `CMC_RST_ZERO;
      vec_reg     <= `CMC_RST_VEC;
      trec_reg    <= `CMC_RST_ZERO;
      fstat_reg   <= `CMC_RST_ZERO;
      rxovf_reg   <= `CMC_RST_ZERO;
      mask_reg    <= '0;
      filt_reg    <= '0;
      busy_reg    <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg  <= w_held_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ctrl_reg    <= ctrl_next;
      abort_reg   <= abort_next;
      cfg_reg     <= cfg_next;
      int_reg     <= int_next;
      vec_reg     <= vec_next;
      trec_reg    <= trec_next;
      fstat_reg   <= fstat_next;
      rxovf_reg   <= rxovf_next;
      mask_reg    <= mask_next;
      filt_reg    <= filt_next;
      busy_reg    <= busy_next;
      irq_reg     <= irq_next;
    end
  end

  cmc_mode_ctrl u_mode (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .req_mode       (cmc_pkg::cmc_op_mode_t'(ctrl_reg[26:24])),
    .mode_safe      (eng_stat.mode_safe),
    .cur_mode       (cur_mode),
    .switch_pending (switch_pending),
    .mode_changed   (mode_changed)
  );

  cmc_ts_timer u_ts (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .cap_en      (ctrl_reg[`CMC_CTRL_CAP]),
    .wr_en       (tmr_wr_en),
    .wr_data     (tmr_wr_data),
    .rx_valid    (eng_stat.rx_valid),
    .timer       (tmr_val),
    .stamp       (rx_stamp),
    .stamp_valid (rx_stamp_valid),
    .rollover    (ts_roll)
  );

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign accept_mask   = mask_reg;
  assign filter_ctrl   = filt_reg;
  assign irq           = irq_reg;

  always_comb begin
    eng_ctl                = '0;
    eng_ctl.module_en      = ctrl_reg[`CMC_CTRL_ON];
    eng_ctl.abort_all_tx   = abort_reg;
    eng_ctl.op_mode        = cur_mode;
    eng_ctl.switch_pending = switch_pending;
    eng_ctl.stop_in_idle   = ctrl_reg[`CMC_CTRL_SIDLE];
    eng_ctl.dncnt          = ctrl_reg[4:0];
    eng_ctl.bit_timing     = cfg_reg;
  end

endmodule

// ---- tb/cmc_eng_model.sv ----
// behavioural protocol engine beside the can control block
`timescale 1ns/1ps
module cmc_eng_model (
  input  logic               aclk,
  input  logic               aresetn,
  input  logic               rx_go,
  input  cmc_pkg::cmc_ctl_t  eng_ctl,
  output cmc_pkg::cmc_stat_t eng_stat
);
  logic [3:0] ab_cnt;
  logic [1:0] sw_d;
  logic       act;
  always_ff @(posedge aclk) begin
    ab_cnt <= (!aresetn || !eng_ctl.abort_all_tx) ? 4'h0 : ab_cnt + 4'(ab_cnt != 4'hf);
    sw_d <= aresetn ? {sw_d[0], eng_ctl.switch_pending} : 2'h0;
    act <= aresetn && eng_ctl.module_en;
  end
  always_comb begin
    eng_stat = '0;
    eng_stat.tx_aborted_all = (ab_cnt == 4'hf);
    eng_stat.mode_safe = sw_d[1];
    eng_stat.module_active_flag = act;
    eng_stat.rx_valid = rx_go;
    eng_stat.int_events[0] = rx_go;
    eng_stat.vector = 32'h0000_0040;
  end
endmodule

// ---- tb/cmc_chk_assertions.sv ----
// port assertions of the can control block
`timescale 1ns/1ps
module cmc_chk (
  input logic               aclk,
  input logic               aresetn,
  input logic               s_axi_awready,
  input logic               s_axi_bvalid,
  input logic               s_axi_bready,
  input logic [1:0]         s_axi_bresp,
  input logic               s_axi_arready,
  input logic               s_axi_rvalid,
  input logic [31:0]        s_axi_rdata,
  input logic [1:0]         s_axi_rresp,
  input logic               rx_stamp_valid,
  input logic               irq,
  input cmc_pkg::cmc_stat_t eng_stat,
  input cmc_pkg::cmc_ctl_t  eng_ctl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_abort_hold: assert property (eng_ctl.abort_all_tx && !eng_stat.tx_aborted_all
    |=> eng_ctl.abort_all_tx) else $error("abort dropped early");
  a_mode_safe: assert property ($changed(eng_ctl.op_mode)
    |-> $past(eng_ctl.switch_pending) && $past(eng_stat.mode_safe))
    else $error("mode changed unsafely");
  a_mode_legal: assert property (eng_ctl.op_mode != 3'h5 && eng_ctl.op_mode != 3'h6)
    else $error("reserved mode entered");
  a_reset_mode: assert property ($rose(aresetn)
    |-> eng_ctl.op_mode == 3'h4 && !eng_ctl.module_en && !irq) else $error("bad reset state");
  a_stamp_cause: assert property (rx_stamp_valid |-> $past(eng_stat.rx_valid))
    else $error("stamp without reception");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 0)
    else $error("error read not zero");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken early");
endmodule
bind cmc_can_module_control cmc_chk u_chk (.*);

// ---- tb/tb.sv ----
// self-checking bench of the can control block
`timescale 1ns/1ps
module tb;
  logic aclk = 0, aresetn = 0, rx_go = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rx_stamp_valid, irq;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] rx_stamp;
  logic [3:0][31:0] accept_mask, filter_ctrl;
  cmc_pkg::cmc_stat_t eng_stat;
  cmc_pkg::cmc_ctl_t eng_ctl;
  logic [33:0] qr[$];
  logic [1:0] qb[$];
  int n_mismatch = 0, num_checks = 0, n;
  cmc_can_module_control dut (.*);
  cmc_eng_model model (.*);
  initial forever #20 aclk = ~aclk;
  task chk(input logic [33:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task tmo(input int k);
    if (k >= 60) begin
      n_mismatch++;
      $display("ERROR %0t wait timed out", $time);
      stop_test;
    end
  endtask
  // one bus transfer: w selects write, e is the expected response
  task ax(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [1:0] e = 0);
    @(posedge aclk);
    if (w) qb.push_back(e);
    else qr.push_back({e, d});
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    s_axi_awaddr <= {16'h0, a};
    s_axi_araddr <= {16'h0, a};
    s_axi_wdata <= d;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    tmo(n);
  endtask
  task rx(input logic e, input logic [15:0] t);
    logic s;
    s = 0;
    @(posedge aclk);
    rx_go <= 1;
    @(posedge aclk);
    rx_go <= 0;
    repeat (3) begin
      @(posedge aclk);
      s = s | rx_stamp_valid;
    end
    chk(34'(s), 34'(e));
    chk(34'(rx_stamp), 34'(t));
  endtask
  task ci(input logic e);
    @(negedge aclk);
    chk(34'(irq), 34'(e));
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, qr.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(qb.pop_front()));
  end
  initial begin
    logic [31:0] m, c;
    logic [2:0] md [7];
    md = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5, 3'h4};
    c = $urandom(32'hf065761c);
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    ax(0, 16'hc000, 32'h0480_0000);
    ax(0, 16'hc030, 32'h0000_0040);
    ax(1, 16'hc000, 32'hf400_a01f);
    ax(0, 16'hc000, 32'h0480_a81f);
    ax(1, 16'hc004, 32'h1f);
    ax(0, 16'hc000, 32'h0480_a800);
    ax(1, 16'hc008, 32'h3);
    ax(0, 16'hc000, 32'h0480_a803);
    ax(1, 16'hc00c, 32'h2001);
    ax(0, 16'hc000, 32'h0480_8802);
    for (int i = 0; i < 4; i++) begin
      m = $urandom;
      ax(1, 16'hc010 + 16'(4 * i), m);
      c = (i == 0) ? m : (i == 1) ? c & ~m : (i == 2) ? c | m : c ^ m;
      ax(0, 16'hc010, c & 32'h0047_ffff);
    end
    m = $urandom;
    ax(1, 16'hc0b0, m);
    ax(0, 16'hc0b0, m & 32'hffeb_ffff);
    chk(34'(accept_mask[3]), 34'(m & 32'hffeb_ffff));
    ax(1, 16'hc0c8, m);
    chk(34'(filter_ctrl[0]), 34'(m));
    $display("test registers done");
    foreach (md[i]) begin
      ax(1, 16'hc000, {5'h0, md[i], 24'h8002});
      if (md[i] != 3'h5) begin
        for (n = 0; n < 60 && eng_ctl.op_mode !== md[i]; n++) @(posedge aclk);
        tmo(n);
        ax(0, 16'hc000, {5'h0, md[i], md[i], 21'h8802});
      end else begin
        ax(0, 16'hc000, 32'h05e0_8802);
      end
    end
    ax(1, 16'hc008, 32'h0800_0000);
    ax(1, 16'hc004, 32'h0800_0000);
    ax(0, 16'hc000, 32'h0c80_8802);
    for (n = 0; n < 60 && eng_ctl.abort_all_tx !== 0; n++) @(posedge aclk);
    tmo(n);
    ax(0, 16'hc000, 32'h0480_8802);
    $display("test mode and abort done");
    ax(1, 16'hc070, 32'h0005_0003);
    rx(0, 16'h0000);
    ax(0, 16'hc070, 32'h0005_0003);
    ax(0, 16'hc020, 32'h9);
    ci(0);
    ax(1, 16'hc028, 32'h0001_0000);
    ci(1);
    ax(1, 16'hc020, 32'h0001_0009);
    ci(0);
    ax(0, 16'hc020, 32'h0001_0000);
    ax(1, 16'hc070, 32'h0005_ffff);
    ax(1, 16'hc008, 32'h0010_0000);
    rx(1, 16'h0005);
    $display("test timestamp and interrupt done");
    ax(0, 16'hc090, 32'h0, 2'h2);
    ax(1, 16'hc090, 32'h1, 2'h2);
    ax(1, 16'hc004, 32'h8000);
    chk(34'(eng_ctl.module_en), 34'h0);
    ax(0, 16'hc000, 32'h0490_0002);
    $display("test error and disable done");
    stop_test;
  end
endmodule
